// [logic/phylm_buf.sv]
// Two-entry receive buffer between line decoder and MAC.
// Assumes the consumer may stall at any time.
`timescale 1ns/100ps
`default_nettype none
module phylm_buf #(
    parameter int unsigned W = 5
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    // Drain side
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    logic         v1_r;
    logic [W-1:0] d1_r;
    logic         push;
    logic         pop;

    assign push     = in_valid & ~v1_r;
    assign pop      = out_valid & out_ready;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            v1_r      <= 1'b0;
            in_ready  <= 1'b1;
            out_data  <= '0;
            d1_r      <= '0;
        end else if (pop && v1_r) begin
            out_data <= d1_r;
            v1_r     <= 1'b0;
            in_ready <= 1'b1;
        end else if (pop || !out_valid) begin
            out_valid <= push;
            out_data  <= in_data;
        end else if (push) begin
            d1_r <= in_data;
            v1_r <= 1'b1;
            in_ready <= 1'b0;
        end
    end
endmodule : phylm_buf
`default_nettype wire

// [logic/phylm_pkg.sv]
// Shared constants and types for the link mode and fault status block.
// Assumes one 20 MHz clock and synchronous active-high reset.
package phylm_pkg;
    localparam int unsigned CLK_MHZ         = 20;
    localparam int unsigned LINK_PULSE_US   = 16000;
    localparam int unsigned LINK_PULSE_CYC  = LINK_PULSE_US * CLK_MHZ;
    localparam int unsigned SOFT_RST_US     = 258;
    localparam int unsigned SOFT_RST_CYC    = SOFT_RST_US * CLK_MHZ;
    localparam int unsigned PREAMBLE_BITS   = 32;
    localparam int unsigned HDR_BITS        = 14;
    localparam int unsigned DATA_BITS       = 16;

    // Register numbers
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_STAT   = 5'h01;
    localparam logic [4:0] REG_ADV    = 5'h04;
    localparam logic [4:0] REG_LPA    = 5'h05;
    localparam logic [4:0] REG_MIICFG = 5'h1a;

    // Bit positions
    localparam int unsigned CTRL_RESET   = 15;
    localparam int unsigned CTRL_SPEED   = 13;
    localparam int unsigned CTRL_AN_EN   = 12;
    localparam int unsigned CTRL_PWRDN   = 11;
    localparam int unsigned CTRL_AN_RST  = 9;
    localparam int unsigned CTRL_DUPLEX  = 8;
    localparam int unsigned STAT_AN_DONE = 5;
    localparam int unsigned STAT_RFAULT  = 4;
    localparam int unsigned STAT_LINK    = 2;
    localparam int unsigned PAGE_RFAULT  = 13;
    localparam int unsigned PAGE_100FD   = 8;
    localparam int unsigned PAGE_100HD   = 7;
    localparam int unsigned PAGE_10FD    = 6;
    localparam int unsigned PAGE_10HD    = 5;
    localparam int unsigned MIICFG_DRIVE = 11;

    // Reset values, management frame codes and strapped PHY addresses
    localparam logic [15:0] CTRL_RST_VAL   = 16'h3100;
    localparam logic [15:0] STAT_FIXED     = 16'h7808;
    localparam logic [15:0] ADV_RST_VAL    = 16'h01e1;
    localparam logic [1:0]  MDIO_ST        = 2'h1;
    localparam logic [1:0]  MDIO_OP_RD     = 2'h2;
    localparam logic [1:0]  MDIO_OP_WR     = 2'h1;
    localparam logic [4:0]  PHY_ADDR_2     = 5'h1c;
    localparam logic [4:0]  PHY_ADDR_3     = 5'h1d;

    typedef struct packed {
        logic       err;
        logic [3:0] nib;
    } phylm_rx_t;

    localparam int unsigned RX_W = $bits(phylm_rx_t);

    typedef enum { AN_FORCED, AN_ABILITY, AN_LINKED } phylm_an_t;
    typedef enum { MD_PRE, MD_HDR, MD_TA, MD_DATA } phylm_md_t;
endpackage : phylm_pkg

// [logic/phylm_top.sv]
// Link mode resolution, fault status and management registers.
// Assumes line-side detectors give synchronous pulses and levels.
`timescale 1ns/100ps
`default_nettype none
module phylm_top #(
    parameter int unsigned LP_CYC   = phylm_pkg::LINK_PULSE_CYC,
    parameter int unsigned SRST_CYC = phylm_pkg::SOFT_RST_CYC
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // Straps
    input  wire logic [1:0]           addr_strap,
    input  wire logic [15:0]          adv_strap,
    // Management pins
    input  wire logic                 mdc,
    input  wire logic                 mdio_in,
    output logic                      mdio_out,
    output logic                      mdio_oe,
    // Line side detectors
    input  wire logic                 lp_page_vld,
    input  wire logic [15:0]          lp_page,
    input  wire logic                 nlp_det,
    input  wire logic                 idle_det,
    input  wire logic                 link_ok,
    // Line side controls
    output logic                      flp_send,
    output logic [15:0]               adv_word,
    output logic                      tx_idle_sym,
    output logic                      tx_link_pulse,
    output logic                      port_off,
    // Receive stream from decoder
    input  wire logic                 rx_in_valid,
    input  wire phylm_pkg::phylm_rx_t rx_in,
    output logic                      rx_in_ready,
    // MAC side
    input  wire logic                 mac_tx_en,
    output logic                      mac_rx_valid,
    output phylm_pkg::phylm_rx_t      mac_rx,
    input  wire logic                 mac_rx_ready,
    output logic                      mii_rate_100,
    output logic                      mii_full_dup,
    output logic                      mii_drive_hi
);
    import phylm_pkg::*;

    logic [15:0] ctrl_r, adv_r, adv_hw_r, lpa_r, miicfg_r;
    logic        rf_lh_r, an_done_r, link_r, spd_r, dup_r;
    logic [4:0]  phy_addr_r;
    logic [12:0] srst_cnt_r;
    logic [24:0] lp_cnt_r;
    phylm_an_t   an_r;
    phylm_md_t   md_r;
    logic        mdc_d_r, ones_ok_r, rd_r, wr_r;
    logic [5:0]  ones_r;
    logic [4:0]  cnt_r, wa_r;
    logic [15:0] sh_r;
    logic        wr_stb_r, rd_stat_r;
    logic [15:0] wd_r;
    logic [4:0]  wreg_r;
    logic        mdc_rise, hdr_last, pwrdn;
    logic [15:0] hdr;
    phylm_rx_t   buf_out;
    logic        buf_vld, buf_rdy;

    function automatic logic [15:0] reg_read(input logic [4:0] a);
        case (a)
            REG_CTRL:   reg_read = ctrl_r;
            REG_STAT:   reg_read = STAT_FIXED
                                   | (16'(an_done_r) << STAT_AN_DONE)
                                   | (16'(rf_lh_r) << STAT_RFAULT)
                                   | (16'(link_r) << STAT_LINK);
            REG_ADV:    reg_read = adv_r;
            REG_LPA:    reg_read = lpa_r;
            REG_MIICFG: reg_read = miicfg_r;
            default:    reg_read = 16'h0000;
        endcase
    endfunction : reg_read

    function automatic logic wr_hit(input logic [4:0] a);
        wr_hit = wr_stb_r && (wreg_r == a);
    endfunction : wr_hit

    assign mdc_rise = mdc && !mdc_d_r;
    assign hdr      = {sh_r[14:0], mdio_in};
    assign hdr_last = (cnt_r == 5'(HDR_BITS - 1));
    assign pwrdn    = ctrl_r[CTRL_PWRDN];

    // Strap capture at reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            case (addr_strap)
                2'h0:    phy_addr_r <= 5'h00;
                2'h1:    phy_addr_r <= 5'h01;
                2'h2:    phy_addr_r <= PHY_ADDR_2;
                default: phy_addr_r <= PHY_ADDR_3;
            endcase
            adv_hw_r <= adv_strap;
        end
    end

    // Management frame engine
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mdc_d_r <= 1'b0;
            md_r <= MD_PRE;
            ones_r <= '0;
            cnt_r <= '0;
            sh_r <= '0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            wa_r <= '0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            wr_stb_r <= 1'b0;
            rd_stat_r <= 1'b0;
            wd_r <= '0;
            wreg_r <= '0;
        end else begin
            mdc_d_r <= mdc;
            wr_stb_r <= 1'b0;
            rd_stat_r <= 1'b0;
            if (mdc_rise) begin
                case (md_r)
                    MD_PRE: begin
                        if (mdio_in) begin
                            if (ones_r != 6'(PREAMBLE_BITS))
                                ones_r <= ones_r + 6'h01;
                        end else begin
                            ones_r <= '0;
                            if (ones_r == 6'(PREAMBLE_BITS)) begin
                                md_r <= MD_HDR;
                                cnt_r <= 5'h01;
                                sh_r <= '0;
                            end
                        end
                    end
                    MD_HDR: begin
                        sh_r <= hdr;
                        cnt_r <= cnt_r + 5'h01;
                        if (hdr_last) begin
                            md_r <= MD_TA;
                            cnt_r <= '0;
                            wa_r <= hdr[4:0];
                            rd_r <= hdr[13:12] == MDIO_ST
                                    && hdr[11:10] == MDIO_OP_RD
                                    && hdr[9:5] == phy_addr_r;
                            wr_r <= hdr[13:12] == MDIO_ST
                                    && hdr[11:10] == MDIO_OP_WR
                                    && hdr[9:5] == phy_addr_r;
                        end
                    end
                    MD_TA: begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == 5'h00) begin
                            mdio_oe <= rd_r;
                            mdio_out <= 1'b0;
                            sh_r <= reg_read(wa_r);
                            rd_stat_r <= rd_r && wa_r == REG_STAT;
                        end else begin
                            md_r <= MD_DATA;
                            cnt_r <= '0;
                            mdio_out <= sh_r[15];
                            sh_r <= {sh_r[14:0], 1'b0};
                        end
                    end
                    MD_DATA: begin
                        cnt_r <= cnt_r + 5'h01;
                        mdio_out <= sh_r[15];
                        sh_r <= rd_r ? {sh_r[14:0], 1'b0} : hdr;
                        if (cnt_r == 5'(DATA_BITS - 1)) begin
                            md_r <= MD_PRE;
                            mdio_oe <= 1'b0;
                            mdio_out <= 1'b0;
                            wr_stb_r <= wr_r;
                            wd_r <= hdr;
                            wreg_r <= wa_r;
                        end
                    end
                    default: md_r <= MD_PRE;
                endcase
            end
        end
    end

    // Control register with self-clearing soft reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_r <= CTRL_RST_VAL;
            srst_cnt_r <= '0;
        end else if (ctrl_r[CTRL_RESET]) begin
            ctrl_r[CTRL_AN_RST] <= 1'b0;
            if (srst_cnt_r == 13'(SRST_CYC - 1)) begin
                ctrl_r <= CTRL_RST_VAL;
                srst_cnt_r <= '0;
            end else begin
                srst_cnt_r <= srst_cnt_r + 13'h0001;
            end
        end else if (wr_hit(REG_CTRL)) begin
            ctrl_r <= wd_r;
        end else if (an_r == AN_ABILITY) begin
            ctrl_r[CTRL_AN_RST] <= 1'b0;
        end
    end

    // Advertisement and drive strength registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            adv_r <= ADV_RST_VAL;
            miicfg_r <= '0;
        end else if (ctrl_r[CTRL_RESET]) begin
            adv_r <= adv_hw_r;
            miicfg_r <= '0;
        end else begin
            if (wr_hit(REG_ADV))
                adv_r <= wd_r;
            if (wr_hit(REG_MIICFG))
                miicfg_r <= wd_r;
        end
    end

    // Negotiation and parallel detection
    always_ff @(posedge core_clk) begin
        if (srst || ctrl_r[CTRL_RESET]) begin
            an_r <= AN_ABILITY;
            an_done_r <= 1'b0;
            lpa_r <= '0;
            spd_r <= 1'b1;
            dup_r <= 1'b1;
        end else if (!ctrl_r[CTRL_AN_EN]) begin
            an_r <= AN_FORCED;
            an_done_r <= 1'b0;
            spd_r <= ctrl_r[CTRL_SPEED];
            dup_r <= ctrl_r[CTRL_DUPLEX];
        end else begin
            case (an_r)
                AN_ABILITY: begin
                    an_done_r <= 1'b0;
                    if (lp_page_vld) begin
                        lpa_r <= lp_page;
                        an_done_r <= 1'b1;
                        an_r <= AN_LINKED;
                        if (adv_r[PAGE_100FD] && lp_page[PAGE_100FD]) begin
                            spd_r <= 1'b1;
                            dup_r <= 1'b1;
                        end else if (adv_r[PAGE_100HD]
                                     && lp_page[PAGE_100HD]) begin
                            spd_r <= 1'b1;
                            dup_r <= 1'b0;
                        end else if (adv_r[PAGE_10FD]
                                     && lp_page[PAGE_10FD]) begin
                            spd_r <= 1'b0;
                            dup_r <= 1'b1;
                        end else begin
                            spd_r <= 1'b0;
                            dup_r <= 1'b0;
                        end
                    end else if (idle_det) begin
                        spd_r <= 1'b1;
                        dup_r <= 1'b0;
                        an_r <= AN_LINKED;
                    end else if (nlp_det) begin
                        spd_r <= 1'b0;
                        dup_r <= 1'b0;
                        an_r <= AN_LINKED;
                    end
                end
                AN_LINKED: begin
                    // Remote fault does not drop the link
                    if (!link_ok || ctrl_r[CTRL_AN_RST])
                        an_r <= AN_ABILITY;
                end
                default: an_r <= AN_ABILITY;
            endcase
        end
    end

    // Latched-high remote fault status
    always_ff @(posedge core_clk) begin
        if (srst || ctrl_r[CTRL_RESET])
            rf_lh_r <= 1'b0;
        else if (lp_page_vld && an_r == AN_ABILITY
                 && lp_page[PAGE_RFAULT])
            rf_lh_r <= 1'b1;
        else if (rd_stat_r)
            rf_lh_r <= 1'b0;
    end

    // Line and MAC side mode outputs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            link_r <= 1'b0;
            flp_send <= 1'b0;
            adv_word <= '0;
            tx_idle_sym <= 1'b0;
            port_off <= 1'b0;
            mii_rate_100 <= 1'b0;
            mii_full_dup <= 1'b0;
            mii_drive_hi <= 1'b0;
        end else begin
            link_r <= link_ok && an_r != AN_ABILITY && !pwrdn;
            flp_send <= an_r == AN_ABILITY && ctrl_r[CTRL_AN_EN]
                        && !pwrdn;
            adv_word <= adv_r;
            tx_idle_sym <= spd_r && !mac_tx_en && an_r != AN_ABILITY
                           && !pwrdn;
            port_off <= pwrdn;
            mii_rate_100 <= spd_r;
            mii_full_dup <= dup_r;
            mii_drive_hi <= miicfg_r[MIICFG_DRIVE];
        end
    end

    // Periodic 10 Mb/s link pulse
    always_ff @(posedge core_clk) begin
        if (srst || spd_r || an_r == AN_ABILITY || pwrdn) begin
            lp_cnt_r <= '0;
            tx_link_pulse <= 1'b0;
        end else begin
            tx_link_pulse <= 1'b0;
            if (lp_cnt_r == 25'(LP_CYC - 1)) begin
                lp_cnt_r <= '0;
                tx_link_pulse <= !mac_tx_en;
            end else begin
                lp_cnt_r <= lp_cnt_r + 25'h0000001;
            end
        end
    end

    // Receive path buffering
    phylm_buf #(.W(RX_W)) u_buf (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (rx_in_valid),
        .in_data   (rx_in),
        .in_ready  (buf_rdy),
        .out_valid (buf_vld),
        .out_data  (buf_out),
        .out_ready (mac_rx_ready)
    );

    assign rx_in_ready  = buf_rdy;
    assign mac_rx_valid = buf_vld;
    assign mac_rx       = buf_out;
endmodule : phylm_top
`default_nettype wire

// [tb/phylm_chk_checker.sv]
// Checker for the link mode block, port relations only.
// Assumes it is bound into phylm_top on the core clock.
`timescale 1ns/100ps
`default_nettype none
module phylm_chk #(
    parameter int unsigned LP_CYC   = 20,
    parameter int unsigned SRST_CYC = 8
) (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 srst,
    // Management pins
    input wire logic                 mdc,
    input wire logic                 mdio_out,
    input wire logic                 mdio_oe,
    // Line controls
    input wire logic                 tx_idle_sym,
    input wire logic                 tx_link_pulse,
    input wire logic                 mii_rate_100,
    // Streams
    input wire logic                 rx_in_valid,
    input wire logic                 rx_in_ready,
    input wire logic                 mac_rx_valid,
    input wire phylm_pkg::phylm_rx_t mac_rx,
    input wire logic                 mac_rx_ready
);
    import phylm_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    rx_hold_a: assert property (mac_rx_valid && !mac_rx_ready
        |=> mac_rx_valid && $stable(mac_rx))
        else $error("stalled word changed or dropped");
    rx_push_a: assert property (rx_in_valid && rx_in_ready
        |=> mac_rx_valid)
        else $error("accepted word not offered");
    rx_empty_a: assert property (!mac_rx_valid && !$past(srst)
        |-> rx_in_ready)
        else $error("empty buffer refuses input");
    rx_full_a: assert property (!rx_in_ready && !$past(srst)
        |-> mac_rx_valid)
        else $error("refusal without held words");
    idle_rate_a: assert property (tx_idle_sym
        |-> mii_rate_100 || $fell(mii_rate_100))
        else $error("idle symbols outside fast mode");
    pulse_rate_a: assert property (tx_link_pulse
        |-> !mii_rate_100 || $rose(mii_rate_100))
        else $error("link pulse in fast mode");
    pulse_gap_a: assert property (tx_link_pulse
        |=> !tx_link_pulse [*8])
        else $error("link pulses too close");
    ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out)
        else $error("turnaround bit not zero");
    out_edge_a: assert property (!$stable(mdio_out)
        |-> ($past(mdc) && !$past(mdc, 2)) || ($past(mdc, 2) && !$past(mdc, 3)))
        else $error("read data moved off a clock rise");
endmodule : phylm_chk

bind phylm_top phylm_chk #(.LP_CYC(LP_CYC), .SRST_CYC(SRST_CYC)) phylm_chk_i (
    .core_clk(core_clk), .srst(srst), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .tx_idle_sym(tx_idle_sym),
    .tx_link_pulse(tx_link_pulse), .mii_rate_100(mii_rate_100),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
    .mac_rx_valid(mac_rx_valid), .mac_rx(mac_rx), .mac_rx_ready(mac_rx_ready));
`default_nettype wire

// [tb/phylm_lpm.sv]
// Link partner model: pages, link pulses or idles on command.
// Assumes mode is driven by the bench off the rising edge.
`timescale 1ns/100ps
`default_nettype none
module phylm_lpm (
    // Clock
    input  wire logic        core_clk,
    // Mode: 0 down, 1 pages, 2 link pulses, 3 idles
    input  wire logic [1:0]  mode,
    input  wire logic [15:0] page,
    input  wire logic        flp_send,
    // Detector outputs
    output var  logic        lp_page_vld,
    output var  logic [15:0] lp_page,
    output var  logic        nlp_det,
    output var  logic        idle_det,
    output var  logic        link_ok
);
    logic [1:0] tick_r = 2'h0;

    always_ff @(posedge core_clk) begin
        tick_r <= tick_r + 2'h1;
    end

    always_comb begin
        lp_page_vld = mode == 2'h1 && flp_send && tick_r == 2'h0;
        lp_page     = lp_page_vld ? page : ~page;
        nlp_det     = mode == 2'h2 && tick_r == 2'h0;
        idle_det    = mode == 2'h3;
        link_ok     = mode != 2'h0;
    end
endmodule : phylm_lpm
`default_nettype wire

// [tb/tb.sv]
// Bench: management frames, forced and negotiated modes, stream stall.
// Assumes checker bound and partner model compiled beside it.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import phylm_pkg::*;
    localparam int unsigned LPC = 20;
    localparam int unsigned SRC = 400;
    logic        core_clk = 1'b0, srst = 1'b1, mdc = 1'b0;
    logic        tb_bit = 1'b1, tb_rel = 1'b0, mac_tx_en = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [1:0]  strap = 2'h2;
    logic [15:0] page = 16'h0;
    logic        rx_in_valid = 1'b0, mac_rx_ready = 1'b0;
    phylm_rx_t   rx_in = 5'h0;
    logic        mdio_in, mdio_out, mdio_oe, lp_page_vld, nlp_det;
    logic        idle_det, link_ok, flp_send, tx_idle_sym, tx_link_pulse;
    logic        port_off, rx_in_ready, mac_rx_valid, mii_rate_100;
    logic        mii_full_dup, mii_drive_hi;
    logic [15:0] lp_page, adv_word;
    phylm_rx_t   mac_rx;
    int          err_total = 0;
    int          tests_run = 0;

    // Pulled-up data line shared with the device
    assign mdio_in = tb_rel ? (mdio_oe ? mdio_out : 1'b1) : tb_bit;

    phylm_top #(.LP_CYC(LPC), .SRST_CYC(SRC)) phylm_top_i (
        .core_clk, .srst, .addr_strap(strap), .adv_strap(16'h0061), .mdc,
        .mdio_in, .mdio_out, .mdio_oe, .lp_page_vld, .lp_page, .nlp_det,
        .idle_det, .link_ok, .flp_send, .adv_word, .tx_idle_sym,
        .tx_link_pulse, .port_off, .rx_in_valid, .rx_in, .rx_in_ready,
        .mac_tx_en, .mac_rx_valid, .mac_rx, .mac_rx_ready, .mii_rate_100,
        .mii_full_dup, .mii_drive_hi);

    phylm_lpm phylm_lpm_i (.core_clk, .mode, .page, .flp_send, .lp_page_vld,
        .lp_page, .nlp_det, .idle_det, .link_ok);

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // One management frame, mdc at a quarter of the core rate
    task automatic frame(input logic rd, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] q);
        logic [63:0] f;
        f = {32'hffffffff, MDIO_ST, rd ? MDIO_OP_RD : MDIO_OP_WR, pa, ra,
             2'h2, wd};
        q = 16'h0;
        for (int n = 1; n <= 64; n++) begin
            mdc = 1'b0;
            tb_bit = f[64-n];
            tb_rel = rd && n >= 47;
            repeat (2) @(negedge core_clk);
            mdc = 1'b1;
            repeat (2) @(negedge core_clk);
            if (rd && n >= 48 && n <= 63) begin
                q = {q[14:0], mdio_in};
            end
        end
        mdc = 1'b0;
        tb_rel = 1'b0;
        tb_bit = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask : frame

    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] q;
        frame(1'b0, PHY_ADDR_2, ra, wd, q);
    endtask : wr

    task automatic rdc(input logic [4:0] ra, output logic [15:0] q);
        frame(1'b1, PHY_ADDR_2, ra, 16'h0, q);
    endtask : rdc

    // Bounded wait for a resolved mode, then compare
    task automatic settle(input logic r, input logic f);
        int k;
        k = 0;
        while ((mii_rate_100 !== r || mii_full_dup !== f) && k < 400) begin
            @(negedge core_clk);
            k++;
        end
        check({mii_rate_100, mii_full_dup}, {r, f});
        if (mii_rate_100 !== r || mii_full_dup !== f) finish_test();
    endtask : settle

    initial begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        $display("[ERR] %0t run limit reached", $time);
        finish_test();
    end

    initial begin
        logic [15:0] d;
        int          n;
        repeat (8) @(negedge core_clk);
        srst = 1'b0;
        repeat (2) @(negedge core_clk);
        check(adv_word, ADV_RST_VAL);
        check(flp_send, 1'b1);
        frame(1'b1, 5'h00, REG_CTRL, 16'h0, d);
        check(d, 16'hffff);
        rdc(REG_CTRL, d);
        check(d, CTRL_RST_VAL);
        rdc(5'h03, d);
        check(d, 16'h0);
        wr(REG_MIICFG, 16'h0800);
        check(mii_drive_hi, 1'b1);
        rdc(REG_MIICFG, d);
        check(d, 16'h0800);
        // Forced speed and duplex, all four
        mode = 2'h3;
        for (int i = 0; i < 4; i++) begin
            wr(REG_CTRL, {2'h0, i[1], 4'h0, i[0], 8'h0});
            settle(i[1], i[0]);
            check(tx_idle_sym, i[1]);
            check(flp_send, 1'b0);
            n = 0;
            repeat (100) begin
                @(negedge core_clk);
                n += tx_link_pulse;
            end
            check(16'(n / 4), i[1] ? 16'h0 : 16'h1);
            mac_tx_en = 1'b1;
            repeat (3) @(negedge core_clk);
            check(tx_idle_sym, 1'b0);
            mac_tx_en = 1'b0;
        end
        // Negotiation with a partner reporting a fault
        mode = 2'h1;
        page = 16'h2141;
        wr(REG_ADV, 16'h21e1);
        wr(REG_CTRL, 16'h1200);
        check(adv_word, 16'h21e1);
        settle(1'b1, 1'b1);
        rdc(REG_LPA, d);
        check(d, 16'h2141);
        rdc(REG_STAT, d);
        check(d & 16'h0034, 16'h0034);
        rdc(REG_STAT, d);
        check(d & 16'h0014, 16'h0004);
        // Parallel detection: link pulses, then idles
        for (int j = 2; j < 4; j++) begin
            mode = 2'(j);
            wr(REG_CTRL, 16'h1200);
            settle(j[0], 1'b0);
        end
        wr(REG_CTRL, 16'h8000);
        rdc(REG_CTRL, d);
        check(d[15], 1'b1);
        rdc(REG_CTRL, d);
        check(d, CTRL_RST_VAL);
        rdc(REG_ADV, d);
        check(d, 16'h0061);
        check(mii_drive_hi, 1'b0);
        wr(REG_CTRL, 16'h0800);
        check(port_off, 1'b1);
        // Stalled consumer: two words held, rest refused
        n = 0;
        for (int i = 0; i < 4; i++) begin
            rx_in_valid = 1'b1;
            rx_in = 5'(i + 3);
            n += rx_in_ready;
            @(negedge core_clk);
        end
        rx_in_valid = 1'b0;
        rx_in = ~rx_in;
        check(16'(n), 16'h2);
        mac_rx_ready = 1'b1;
        for (int i = 0; i < 2; i++) begin
            check({mac_rx_valid, mac_rx}, {1'b1, 5'(i + 3)});
            @(negedge core_clk);
        end
        check(mac_rx_valid, 1'b0);
        // Hardware reset with the other strap code
        strap = 2'h3;
        srst = 1'b1;
        repeat (8) @(negedge core_clk);
        srst = 1'b0;
        repeat (2) @(negedge core_clk);
        frame(1'b1, PHY_ADDR_3, REG_CTRL, 16'h0, d);
        check(d, CTRL_RST_VAL);
        rdc(REG_CTRL, d);
        check(d, 16'hffff);
        finish_test();
    end
endmodule : tb
`default_nettype wire
